/* shared/crl_pkg.sv */
`default_nettype none
package crl_pkg;
   // ***********************************
   // register offsets
   // ***********************************
   localparam logic [7:0] OFF_RECOV  = 8'h0A;
   localparam logic [7:0] OFF_STD    = 8'h2F;
   localparam logic [7:0] OFF_REFM   = 8'h36;
   localparam logic [7:0] OFF_G0_LO  = 8'h60;
   localparam logic [7:0] OFF_G0_HI  = 8'h61;
   localparam logic [7:0] OFF_G1_LO  = 8'h62;
   localparam logic [7:0] OFF_G1_HI  = 8'h63;
   localparam logic [7:0] OFF_TOL    = 8'h64;
   localparam logic [7:0] OFF_CHSEL  = 8'hFF;
   // ***********************************
   // field positions
   // ***********************************
   localparam int MANUAL_BIT = 7;
   localparam int RST_LO     = 2;
   localparam int RST_HI     = 3;
   localparam int FLD_BIT    = 1;
   localparam int REFM_LO    = 4;
   localparam int REFM_HI    = 5;
   localparam int FORCE_LO   = 0;
   localparam int FORCE_HI   = 1;
   localparam int STD_LO     = 4;
   localparam int STD_HI     = 7;
   localparam int TOL0_LO    = 0;
   localparam int TOL0_HI    = 3;
   localparam int TOL1_LO    = 4;
   localparam int TOL1_HI    = 7;
   localparam int CHSEL_HI   = 1;
   // ***********************************
   // reset values and codes
   // ***********************************
   localparam logic [7:0] RECOV_RST  = 8'h00;
   localparam logic [7:0] STD_RST    = 8'h02;
   localparam logic [7:0] REFM_RST   = 8'h30;
   localparam logic [7:0] COUNT_RST  = 8'h00;
   localparam logic [7:0] TOL_RST    = 8'h00;
   localparam logic [7:0] CHSEL_RST  = 8'h00;
   localparam logic [1:0] REF_ASSIST = 2'h3;
   localparam logic [6:0] SMB_ADDR7  = 7'h18;
   localparam logic [3:0] NIB_IB     = 4'h2;
   localparam logic [3:0] NIB_CPRI1  = 4'h3;
   localparam logic [3:0] NIB_CPRI2  = 4'h4;
   localparam logic [3:0] NIB_WIDE   = 4'h6;
   localparam logic [3:0] NIB_PROP   = 4'hA;
   localparam logic [3:0] NIB_ILK1   = 4'hB;
   localparam logic [3:0] NIB_ILK2   = 4'hC;
   localparam logic [3:0] NIB_ETH    = 4'hF;
   // divider masks: bit0 = /1, bit1 = /2, bit2 = /4, bit3 = /8
   localparam logic [3:0] DIV1       = 4'h1;
   localparam logic [3:0] DIV8       = 4'h8;
   localparam logic [3:0] DIV_124    = 4'h7;
   localparam logic [3:0] DIV_24     = 4'h6;
   localparam logic [3:0] DIV_2      = 4'h2;
   localparam logic [3:0] DIV_1248   = 4'hF;
   // ***********************************
   // types
   // ***********************************
   typedef enum logic [8:0] {
      SMB_IDLE  = 9'h001,
      SMB_ADDR  = 9'h002,
      SMB_AADDR = 9'h004,
      SMB_REG   = 9'h008,
      SMB_AREG  = 9'h010,
      SMB_WDATA = 9'h020,
      SMB_ADATA = 9'h040,
      SMB_RDATA = 9'h080,
      SMB_RACK  = 9'h100
   } crl_smb_e;
   typedef struct packed {
      logic [7:0] recov;
      logic [7:0] std;
      logic [7:0] refm;
      logic [7:0] g0_lo;
      logic [7:0] g0_hi;
      logic [7:0] g1_lo;
      logic [7:0] g1_hi;
      logic [7:0] tol;
   } crl_chan_s;
   typedef struct packed {
      logic        phase_locked;
      logic        meas_valid;
      logic [14:0] meas_count;
   } crl_loop_s;
   typedef struct packed {
      logic       loop_reset;
      logic       ref_assist;
      logic       restrict_coarse;
      logic       false_lock_en;
      logic       manual_count;
      logic       group;
      logic [3:0] divider;
   } crl_ctrl_s;
   // ***********************************
   // divider set per standard code and group
   // ***********************************
   function automatic logic [3:0] crl_div_mask(input logic [3:0] nib, input logic grp);
      logic [3:0] m;
      m = 4'h0;
      case (nib)
         NIB_IB, NIB_CPRI1 : m = DIV_124;
         NIB_CPRI2, NIB_ILK1 : m = DIV_24;
         NIB_WIDE : m = DIV_1248;
         NIB_PROP : m = DIV_2;
         NIB_ILK2 : m = DIV1;
         NIB_ETH : m = grp ? DIV1 : DIV8;
         default : m = 4'h0;
      endcase
      return m;
   endfunction : crl_div_mask
   function automatic logic [2:0] crl_next_cand(input logic [2:0] cur, input logic [7:0] allowed);
      logic [2:0] c;
      logic [2:0] res;
      logic       found;
      c = cur;
      res = cur;
      found = 1'b0;
      for (int k = 0; k < 8; k++) begin
         c = c + 3'h1;
         if (!found && allowed[c]) begin
            res = c;
            found = 1'b1;
         end
      end
      return res;
   endfunction : crl_next_cand
endpackage : crl_pkg
`default_nettype wire

/* verilog/crl_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module crl_sync
   import crl_pkg::*;
(
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   input  wire logic d_in,
   output logic      level_out,
   output logic      rise_out,
   output logic      fall_out
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } crl_sync_s;
   crl_sync_s q;
   crl_sync_s nxt;
   // s1 is read by s2 only; edges come from s2/s3
   always_comb begin
      nxt = q;
      nxt.s1 = d_in;
      nxt.s2 = q.s1;
      nxt.s3 = q.s2;
   end
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         q <= 3'h7;
      end else begin
         q <= nxt;
      end
   end
   assign level_out = q.s2;
   assign rise_out  = q.s2 & ~q.s3;
   assign fall_out  = ~q.s2 & q.s3;
endmodule : crl_sync
`default_nettype wire

/* verilog/crl_lock_judge.sv */
`timescale 1ns/10ps
`default_nettype none
module crl_lock_judge
   import crl_pkg::*;
(
   input  wire logic [14:0] count_in,
   input  wire logic [14:0] exp0_in,
   input  wire logic [14:0] exp1_in,
   input  wire logic [7:0]  tol_in,
   output logic      [1:0]  in_tol_out
);
   logic [14:0] diff0;
   logic [14:0] diff1;
   // deviation in counts equals the tolerance value itself
   assign diff0 = (count_in > exp0_in) ? (count_in - exp0_in) : (exp0_in - count_in); // R10
   assign diff1 = (count_in > exp1_in) ? (count_in - exp1_in) : (exp1_in - count_in); // R10
   assign in_tol_out[0] = diff0 <= {11'h000, tol_in[TOL0_HI:TOL0_LO]}; // R24
   assign in_tol_out[1] = diff1 <= {11'h000, tol_in[TOL1_HI:TOL1_LO]}; // R24
endmodule : crl_lock_judge
`default_nettype wire

/* verilog/crl_rate_lock.sv */
// Notes on behaviour
// R1 - configuration over open-drain two-wire bus, never drive high
// R2 - known standard code restricts coarse tuning, dividers
// R3 - upper nibble decodes divider sets per group
// R4 - ethernet code: device picks divider and tuning
// R5 - single-frequency standards switch dividers automatically; code C holds /1 in both groups
// R6 - lock only within tolerance of expected count
// R7 - two groups, shared tolerance register
// R8 - host computes expected count as rate times 1280
// R9 - high byte bit 7 selects manual count
// R10 - nibble tolerance gives deviation around expected count
// R11 - host should write all ones to tolerance
// R12 - single-frequency standards: host writes identical counts
// R13 - range mode uses divide-by-1, host may force
// R14 - standards mode auto-switches divider, ethernet also oscillator
// R15 - channel select steers per-channel accesses
// R16 - host sets reference mode bits to 11
// R17 - set-then-clear recovery bits restarts recovery loop
// R18 - after reset, lock to correctly configured input
// R19 - reference mode: device picks capacitor settings itself
// R20 - groups may hold different counts, same dividers; ethernet code uses /8 in group 0 and /1 in group 1
// R21 - reference mode field resets to 11
// R22 - false-lock detector disabled at reset, zero enables
// R23 - per-channel lock output high while locked
// R24 - upper tolerance nibble group 1, lower group 0
// R25 - undefined codes fall back to range, divide-by-1
`timescale 1ns/10ps
`default_nettype none
module crl_rate_lock
   import crl_pkg::*;
(
   input  wire logic             CORE_CLK_IN,
   input  wire logic             RESET_N_IN,
   input  wire logic             SERIAL_CLOCK_LINE_IN,
   output logic                  SERIAL_CLOCK_LINE_OUT,
   output logic                  SERIAL_CLOCK_LINE_OE_OUT,
   input  wire logic             SERIAL_DATA_IN,
   output logic                  SERIAL_DATA_OUT,
   output logic                  SERIAL_DATA_OE_OUT,
   input  wire crl_loop_s [3:0]  LOOP_STATUS_IN,
   output crl_ctrl_s      [3:0]  LOOP_CTRL_OUT,
   output logic           [3:0]  LOCK_OUT
);
   // ***********************************
   // state
   // ***********************************
   typedef struct packed {
      crl_smb_e              st;
      logic [2:0]            cnt;
      logic [7:0]            sh;
      logic                  got;
      logic                  rw;
      logic [7:0]            ptr;
      logic                  sda_oe;
      logic                  sda_o;
      logic                  scl_oe;
      logic                  scl_o;
      logic [7:0]            chan_sel;
      crl_chan_s [3:0]       ch;
      logic [3:0][2:0]       cand;
      logic [3:0]            lock;
      crl_ctrl_s [3:0]       ctrl;
   } crl_top_s;
   crl_top_s          q;
   crl_top_s          nxt;
   logic              scl_lvl;
   logic              scl_rise;
   logic              scl_fall;
   logic              sda_lvl;
   logic              sda_rise;
   logic              sda_fall;
   logic [3:0][1:0]   in_tol;
   logic              do_wr;
   logic [7:0]        waddr;
   logic [7:0]        wdat;
   default clocking cb @(posedge CORE_CLK_IN);
   endclocking
   default disable iff (!RESET_N_IN);
   // ***********************************
   // pin synchronisers
   // ***********************************
   crl_sync u_scl_sync (
      .clk_in    (CORE_CLK_IN),
      .rst_n_in  (RESET_N_IN),
      .d_in      (SERIAL_CLOCK_LINE_IN),
      .level_out (scl_lvl),
      .rise_out  (scl_rise),
      .fall_out  (scl_fall)
   );
   crl_sync u_sda_sync (
      .clk_in    (CORE_CLK_IN),
      .rst_n_in  (RESET_N_IN),
      .d_in      (SERIAL_DATA_IN),
      .level_out (sda_lvl),
      .rise_out  (sda_rise),
      .fall_out  (sda_fall)
   );
   // ***********************************
   // per-channel frequency judges
   // ***********************************
   for (genvar g = 0; g < 4; g++) begin : g_chan
      crl_lock_judge u_judge (
         .count_in   (LOOP_STATUS_IN[g].meas_count),
         .exp0_in    ({q.ch[g].g0_hi[6:0], q.ch[g].g0_lo}), // R7
         .exp1_in    ({q.ch[g].g1_hi[6:0], q.ch[g].g1_lo}), // R20
         .tol_in     (q.ch[g].tol), // R7
         .in_tol_out (in_tol[g])
      );
      // ***********************************
      // per-channel checks
      // ***********************************
      fld_reset_a : assert property (q.ch[g].std[FLD_BIT] |=> !LOOP_CTRL_OUT[g].false_lock_en) // R22
         else $error("false-lock detector enabled while disable bit set");
      eth_div_a : assert property ((q.ch[g].std[STD_HI:STD_LO] == NIB_ETH) [*3] |-> // R3
         (LOOP_CTRL_OUT[g].divider == (LOOP_CTRL_OUT[g].group ? DIV1 : DIV8)))
         else $error("ethernet code gave wrong divider for group");
      range_div_a : assert property (((crl_div_mask(q.ch[g].std[STD_HI:STD_LO], 1'b0) == 4'h0) && // R25
         (q.ch[g].refm[FORCE_HI:FORCE_LO] == 2'h0)) [*3] |-> (LOOP_CTRL_OUT[g].divider == DIV1))
         else $error("undefined code did not fall back to divide-by-1");
      lock_cause_a : assert property ($rose(LOCK_OUT[g]) |-> // R6
         $past(LOOP_STATUS_IN[g].meas_valid && LOOP_STATUS_IN[g].phase_locked && in_tol[g][q.cand[g][2]]))
         else $error("lock rose without an in-tolerance measurement");
      loop_rst_a : assert property ((|q.ch[g].recov[RST_HI:RST_LO]) |=> // R17
         (!LOCK_OUT[g] && LOOP_CTRL_OUT[g].loop_reset))
         else $error("recovery reset bits did not restart the loop");
      lock_phase_a : assert property ((LOCK_OUT[g] && !LOOP_STATUS_IN[g].phase_locked) |=> !LOCK_OUT[g]) // R23
         else $error("lock output held after phase lock was lost");
   end
   // ***********************************
   // register read mux
   // ***********************************
   function automatic logic [7:0] reg_read(input crl_top_s s, input logic [7:0] a);
      crl_chan_s c;
      logic [7:0] r;
      c = s.ch[s.chan_sel[CHSEL_HI:0]];
      r = 8'h00;
      case (a)
         OFF_RECOV : r = c.recov;
         OFF_STD   : r = c.std;
         OFF_REFM  : r = c.refm;
         OFF_G0_LO : r = c.g0_lo;
         OFF_G0_HI : r = c.g0_hi;
         OFF_G1_LO : r = c.g1_lo;
         OFF_G1_HI : r = c.g1_hi;
         OFF_TOL   : r = c.tol;
         OFF_CHSEL : r = s.chan_sel;
         default   : r = 8'h00;
      endcase
      return r;
   endfunction : reg_read
   function automatic crl_top_s top_reset();
      crl_top_s s;
      s = '0;
      s.st = SMB_IDLE;
      s.chan_sel = CHSEL_RST;
      for (int k = 0; k < 4; k++) begin
         s.ch[k] = {RECOV_RST, STD_RST, REFM_RST, COUNT_RST, COUNT_RST, COUNT_RST, COUNT_RST, TOL_RST}; // R21 R22
         s.ctrl[k].false_lock_en = 1'b0;
         s.ctrl[k].ref_assist = 1'b1;
      end
      return s;
   endfunction : top_reset
   // ***********************************
   // next state
   // ***********************************
   always_comb begin
      logic [3:0] nib;
      logic [7:0] allowed;
      logic [7:0] rd;
      logic       known;
      logic       grp;
      nib = 4'h0;
      allowed = 8'h00;
      known = 1'b0;
      grp = 1'b0;
      nxt = q;
      do_wr = 1'b0;
      waddr = q.ptr;
      wdat = q.sh;
      rd = reg_read(q, q.ptr);
      // sda only ever pulled low; released otherwise
      nxt.sda_o = 1'b0; // R1
      nxt.scl_o = 1'b0; // R1
      nxt.scl_oe = 1'b0; // R1
      if (sda_fall && scl_lvl) begin
         nxt.st = SMB_ADDR;
         nxt.cnt = 3'h0;
         nxt.got = 1'b0;
         nxt.sda_oe = 1'b0;
      end else if (sda_rise && scl_lvl) begin
         nxt.st = SMB_IDLE;
         nxt.sda_oe = 1'b0;
      end else begin
         unique case (q.st)
            SMB_IDLE : begin
               nxt.sda_oe = 1'b0;
            end
            SMB_ADDR, SMB_REG, SMB_WDATA : begin
               if (scl_rise) begin
                  nxt.sh = {q.sh[6:0], sda_lvl};
                  nxt.cnt = q.cnt + 3'h1;
                  nxt.got = (q.cnt == 3'h7);
               end else if (scl_fall && q.got) begin
                  nxt.got = 1'b0;
                  nxt.sda_oe = 1'b1; // R1
                  if (q.st == SMB_ADDR) begin
                     nxt.rw = q.sh[0];
                     nxt.st = (q.sh[7:1] == SMB_ADDR7) ? SMB_AADDR : SMB_IDLE;
                     nxt.sda_oe = (q.sh[7:1] == SMB_ADDR7);
                  end else if (q.st == SMB_REG) begin
                     nxt.ptr = q.sh;
                     nxt.st = SMB_AREG;
                  end else begin
                     do_wr = 1'b1;
                     nxt.ptr = q.ptr + 8'h01;
                     nxt.st = SMB_ADATA;
                  end
               end
            end
            SMB_AADDR : begin
               if (scl_fall) begin
                  nxt.cnt = 3'h0;
                  if (q.rw) begin
                     nxt.sh = rd;
                     nxt.sda_oe = ~rd[7];
                     nxt.st = SMB_RDATA;
                  end else begin
                     nxt.sda_oe = 1'b0;
                     nxt.st = SMB_REG;
                  end
               end
            end
            SMB_AREG, SMB_ADATA : begin
               if (scl_fall) begin
                  nxt.cnt = 3'h0;
                  nxt.sda_oe = 1'b0;
                  nxt.st = SMB_WDATA;
               end
            end
            SMB_RDATA : begin
               if (scl_fall) begin
                  if (q.cnt == 3'h7) begin
                     nxt.sda_oe = 1'b0;
                     nxt.ptr = q.ptr + 8'h01;
                     nxt.got = 1'b0;
                     nxt.st = SMB_RACK;
                  end else begin
                     nxt.cnt = q.cnt + 3'h1;
                     nxt.sh = {q.sh[6:0], 1'b0};
                     nxt.sda_oe = ~q.sh[6];
                  end
               end
            end
            SMB_RACK : begin
               if (scl_rise) begin
                  // a nack from the master ends the read burst
                  nxt.st = sda_lvl ? SMB_IDLE : SMB_RACK;
                  nxt.got = ~sda_lvl;
               end else if (scl_fall && q.got) begin
                  nxt.got = 1'b0;
                  nxt.cnt = 3'h0;
                  nxt.sh = rd;
                  nxt.sda_oe = ~rd[7];
                  nxt.st = SMB_RDATA;
               end
            end
         endcase
      end
      // register writes land in the selected channel, except writes to the channel select itself
      if (do_wr) begin
         if (waddr == OFF_CHSEL) begin
            nxt.chan_sel = wdat; // R15
         end else begin
            case (waddr)
               OFF_RECOV : nxt.ch[q.chan_sel[CHSEL_HI:0]].recov = wdat; // R15 R17
               OFF_STD   : nxt.ch[q.chan_sel[CHSEL_HI:0]].std   = wdat; // R15 R2
               OFF_REFM  : nxt.ch[q.chan_sel[CHSEL_HI:0]].refm  = wdat; // R15
               OFF_G0_LO : nxt.ch[q.chan_sel[CHSEL_HI:0]].g0_lo = wdat; // R7
               OFF_G0_HI : nxt.ch[q.chan_sel[CHSEL_HI:0]].g0_hi = wdat; // R9
               OFF_G1_LO : nxt.ch[q.chan_sel[CHSEL_HI:0]].g1_lo = wdat; // R7
               OFF_G1_HI : nxt.ch[q.chan_sel[CHSEL_HI:0]].g1_hi = wdat; // R9
               OFF_TOL   : nxt.ch[q.chan_sel[CHSEL_HI:0]].tol   = wdat; // R10
               default   : nxt.chan_sel = q.chan_sel;
            endcase
         end
      end
      // ***********************************
      // divider hunt and lock per channel
      // ***********************************
      for (int i = 0; i < 4; i++) begin
         nib = q.ch[i].std[STD_HI:STD_LO];
         known = (crl_div_mask(nib, 1'b0) != 4'h0); // R2
         if (known) begin
            allowed = {crl_div_mask(nib, 1'b1), crl_div_mask(nib, 1'b0)}; // R3 R4 R14
         end else begin
            // forced divider only honoured outside standards mode
            allowed = {2{4'(DIV1 << q.ch[i].refm[FORCE_HI:FORCE_LO])}}; // R13 R25
         end
         grp = q.cand[i][2];
         if (|q.ch[i].recov[RST_HI:RST_LO]) begin
            nxt.lock[i] = 1'b0; // R17
            nxt.cand[i] = crl_next_cand(3'h7, allowed); // R17
         end else if (!allowed[q.cand[i]]) begin
            nxt.lock[i] = 1'b0;
            nxt.cand[i] = crl_next_cand(q.cand[i], allowed); // R5
         end else if (!LOOP_STATUS_IN[i].phase_locked) begin
            nxt.lock[i] = 1'b0; // R23
            if (LOOP_STATUS_IN[i].meas_valid) begin
               nxt.cand[i] = crl_next_cand(q.cand[i], allowed); // R5 R14
            end
         end else if (LOOP_STATUS_IN[i].meas_valid) begin
            if (in_tol[i][grp] && (grp ? q.ch[i].g1_hi[MANUAL_BIT] : q.ch[i].g0_hi[MANUAL_BIT])) begin
               nxt.lock[i] = 1'b1; // R6 R18 R9
            end else begin
               nxt.lock[i] = 1'b0; // R6
               nxt.cand[i] = crl_next_cand(q.cand[i], allowed); // R5 R14
            end
         end
         nxt.ctrl[i].loop_reset      = |q.ch[i].recov[RST_HI:RST_LO]; // R17
         nxt.ctrl[i].ref_assist      = (q.ch[i].refm[REFM_HI:REFM_LO] == REF_ASSIST); // R16 R19
         nxt.ctrl[i].restrict_coarse = known; // R2
         nxt.ctrl[i].false_lock_en   = ~q.ch[i].std[FLD_BIT]; // R22
         nxt.ctrl[i].manual_count    = grp ? q.ch[i].g1_hi[MANUAL_BIT] : q.ch[i].g0_hi[MANUAL_BIT]; // R9
         nxt.ctrl[i].group           = grp; // R14
         nxt.ctrl[i].divider         = 4'(DIV1 << q.cand[i][1:0]); // R5
      end
   end
   always_ff @(posedge CORE_CLK_IN) begin
      if (!RESET_N_IN) begin
         q <= top_reset();
      end else begin
         q <= nxt;
      end
   end
   // ***********************************
   // outputs
   // ***********************************
   assign SERIAL_CLOCK_LINE_OUT    = q.scl_o;
   assign SERIAL_CLOCK_LINE_OE_OUT = q.scl_oe;
   assign SERIAL_DATA_OUT          = q.sda_o;
   assign SERIAL_DATA_OE_OUT       = q.sda_oe;
   assign LOOP_CTRL_OUT            = q.ctrl;
   assign LOCK_OUT                 = q.lock; // R23
   // ***********************************
   // bus checks
   // ***********************************
   sda_edge_a : assert property ($changed(SERIAL_DATA_OE_OUT) |-> !scl_lvl) // R1
      else $error("data line changed while clock high");
   ref_reset_a : assert property (disable iff (1'b0) !RESET_N_IN |=> // R21
      (q.ch[0].refm[REFM_HI:REFM_LO] == REF_ASSIST && q.ch[3].refm[REFM_HI:REFM_LO] == REF_ASSIST))
      else $error("reference mode field not 11 after reset");
   chan_write_a : assert property ((do_wr && waddr == OFF_STD) |=> // R15
      (q.ch[$past(q.chan_sel[CHSEL_HI:0])].std == $past(wdat)))
      else $error("standard-select write missed the selected channel");
endmodule : crl_rate_lock
`default_nettype wire

/* bench/crl_smb_host.sv */
`timescale 1ns/10ps
`default_nettype none
module crl_smb_host
   import crl_pkg::*;
(
   input  wire logic clk_in,
   input  wire logic sda_in,
   output logic      scl_oe_out,
   output logic      sda_oe_out
);
   // ****************************
   // two-wire host, pulls low only
   // ****************************
   initial begin
      scl_oe_out = 1'b0;
      sda_oe_out = 1'b0;
   end
   // every step lands on a falling core edge, 4 cycles per half bit
   task automatic hp(input int n);
      repeat (n) @(negedge clk_in);
   endtask : hp
   // slave may still hold its ack for ~3 cycles, so wait a full half bit first
   task automatic start_c();
      sda_oe_out = 1'b0;
      hp(4);
      scl_oe_out = 1'b0;
      hp(4);
      sda_oe_out = 1'b1;
      hp(4);
      scl_oe_out = 1'b1;
   endtask : start_c
   task automatic bit_c(input logic b, output logic s);
      sda_oe_out = ~b;
      hp(4);
      scl_oe_out = 1'b0;
      hp(2);
      s = sda_in;
      hp(2);
      scl_oe_out = 1'b1;
   endtask : bit_c
   task automatic byte_c(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_c(tx[i], s);
         rx[i] = s;
      end
      bit_c(1'b1, s);
      ack = ~s;
   endtask : byte_c
   task automatic stop_c();
      sda_oe_out = 1'b1;
      hp(4);
      scl_oe_out = 1'b0;
      hp(4);
      sda_oe_out = 1'b0;
      hp(8);
   endtask : stop_c
   task automatic wr(input logic [7:0] ofs, input logic [7:0] d, output logic ok);
      logic [7:0] x;
      logic       a0, a1, a2;
      start_c();
      byte_c({SMB_ADDR7, 1'b0}, x, a0);
      byte_c(ofs, x, a1);
      byte_c(d, x, a2);
      stop_c();
      ok = a0 & a1 & a2;
   endtask : wr
   // last byte is answered with a nack, which ends the read
   task automatic rd(input logic [7:0] ofs, output logic [7:0] d, output logic ok);
      logic [7:0] x;
      logic       a0, a1, a2, n;
      start_c();
      byte_c({SMB_ADDR7, 1'b0}, x, a0);
      byte_c(ofs, x, a1);
      start_c();
      byte_c({SMB_ADDR7, 1'b1}, x, a2);
      byte_c(8'hFF, d, n);
      stop_c();
      ok = a0 & a1 & a2;
   endtask : rd
endmodule : crl_smb_host
`default_nettype wire

/* bench/crl_rate_lock_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module crl_rate_lock_tb;
   import crl_pkg::*;
   // ****************************
   // bench, channel 0 is exercised
   // ****************************
   localparam int N0 = 10000 * 1280 / 1000;
   localparam int N1 = 103125 * 128 / 1000;
   logic            clk, rst_n, ok, h_scl, h_sda, scl_o, scl_oe, sda_o, sda_oe;
   logic [3:0]      lock;
   crl_loop_s [3:0] st;
   crl_ctrl_s [3:0] ctl;
   int              failures, n_tests;
   logic [7:0]      tbl [9] = '{8'h21, 8'h31, 8'h42, 8'h61, 8'hA2, 8'hB2, 8'hC1, 8'hF8, 8'h51};
   wire logic       scl_w = ~(h_scl | scl_oe);
   wire logic       sda_w = ~(h_sda | sda_oe);
   crl_rate_lock crl_rate_lock_inst (.CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .SERIAL_CLOCK_LINE_IN(scl_w),
      .SERIAL_CLOCK_LINE_OUT(scl_o), .SERIAL_CLOCK_LINE_OE_OUT(scl_oe), .SERIAL_DATA_IN(sda_w),
      .SERIAL_DATA_OUT(sda_o), .SERIAL_DATA_OE_OUT(sda_oe), .LOOP_STATUS_IN(st), .LOOP_CTRL_OUT(ctl),
      .LOCK_OUT(lock));
   crl_smb_host crl_smb_host_inst (.clk_in(clk), .sda_in(sda_w), .scl_oe_out(h_scl), .sda_oe_out(h_sda));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic end_sim();
      $display("checks %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_sim
   task automatic w(input logic [7:0] a, input logic [7:0] v);
      crl_smb_host_inst.wr(a, v, ok);
      chk("wack", 16'h1, ok);
   endtask : w
   task automatic r(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] v;
      crl_smb_host_inst.rd(a, v, ok);
      chk("rack", 16'h1, ok);
      chk("rdata", e, v);
   endtask : r
   // pulse the recovery bits; lock must drop while the loop is held
   task automatic rst_loop();
      w(OFF_RECOV, 8'h0C);
      chk("loop_rst", 16'h2, {ctl[0].loop_reset, lock[0]});
      w(OFF_RECOV, 8'h00);
      repeat (4) @(negedge clk);
   endtask : rst_loop
   task automatic meas(input logic [14:0] c, input logic [5:0] e);
      st[0].meas_count = c;
      st[0].meas_valid = 1'b1;
      @(negedge clk);
      st[0].meas_valid = 1'b0;
      repeat (3) @(negedge clk);
      chk("lock_div", e, {lock[0], ctl[0].group, ctl[0].divider});
   endtask : meas
   initial begin
      rst_n = 1'b0;
      st = '0;
      failures = 0;
      n_tests = 0;
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      chk("rst_out", 16'h2, {lock, ctl[0].ref_assist, ctl[0].false_lock_en});
      r(OFF_STD, 8'h02);
      r(OFF_REFM, 8'h30);
      w(OFF_CHSEL, 8'h00);
      w(OFF_REFM, 8'h30);
      w(OFF_STD, 8'h00);
      chk("fld_en", 16'h1, ctl[0].false_lock_en);
      foreach (tbl[i]) begin
         w(OFF_STD, {tbl[i][7:4], 4'h6});
         rst_loop();
         chk("div", {tbl[i][3:0], 1'b0, tbl[i][7:4] != 4'h5}, {ctl[0].divider, ctl[0].group,
            ctl[0].restrict_coarse});
      end
      w(OFF_REFM, 8'h31);
      rst_loop();
      chk("forced", 16'h2, ctl[0].divider);
      w(OFF_REFM, 8'h30);
      w(OFF_STD, 8'hF6);
      w(OFF_G0_LO, N0[7:0]);
      w(OFF_G0_HI, {1'b1, N0[14:8]});
      w(OFF_G1_LO, N1[7:0]);
      w(OFF_G1_HI, {1'b1, N1[14:8]});
      w(OFF_TOL, 8'hFF);
      r(OFF_TOL, 8'hFF);
      w(OFF_TOL, 8'h3F);
      r(OFF_G0_HI, 8'hB2);
      rst_loop();
      chk("manual", 16'h1, ctl[0].manual_count);
      st[0].phase_locked = 1'b1;
      meas(15'(N0 + 16), 6'h11);
      meas(15'(N1 - 4), 6'h08);
      meas(15'(N0 + 15), 6'h28);
      st[0].phase_locked = 1'b0;
      repeat (3) @(negedge clk);
      chk("unlock", 16'h0, lock);
      // single-frequency standard: both groups carry the same count
      w(OFF_STD, 8'hC6);
      w(OFF_G0_LO, N1[7:0]);
      w(OFF_G0_HI, {1'b1, N1[14:8]});
      rst_loop();
      st[0].phase_locked = 1'b1;
      meas(15'(N1 + 3), 6'h21);
      w(OFF_CHSEL, 8'h01);
      r(OFF_STD, 8'h02);
      w(OFF_REFM, 8'h00);
      chk("ref_mode", 16'h1, {ctl[1].ref_assist, ctl[0].ref_assist});
      w(8'h10, 8'hAA);
      r(8'h10, 8'h00);
      chk("drive_hi", 16'h0, {scl_o, scl_oe, sda_o});
      end_sim();
   end
   initial begin
      repeat (60000) @(posedge clk);
      failures++;
      end_sim();
   end
endmodule : crl_rate_lock_tb
`default_nettype wire
